// ==== design/asrc_core.sv ====
// Behaviour
// - Two 512-word sample stores, left and right
// - Write address is counter plus 16
// - Input counter gives write address, servo ramp
// - 64 taps, or 64 times ratio decimating
// - Load start pointers from servo each period
// - Read address decrements by one per tap
// - ROM step 2^20 or scaled; rollover ends
// - Both channels share one multiply-accumulate
// - Ratio from output versus input counter
// - Ratio fixed at one when upsampling
// - Ratio update needs a change of more than two LSBs, or a new ratio of one
// - Scale input by inverse ratio when decimating
// - Soft mute applied before RAM write
// - Servo integer gives RAM, fraction gives ROM
// - Servo fraction divided by ratio decimating
// - Servo averages output period measurements in slow mode only, input period taken raw
// - Fast settling after start, then slow
// - Settling mute flag while fast mode
// - Coefficients interpolated between stored values
// - Decimation up to 7.75 supported
// - 12-bit mute ramp on input frames
// - Reset clears RAM, mutes, full attenuation
`timescale 1ns/10ps
module asrc_core (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Input frame side
  input  wire logic        inFrame,
  input  wire logic [23:0] inLeft,
  input  wire logic [23:0] inRight,
  input  wire logic        muteIn,
  // Output frame side
  input  wire logic        outFrame,
  input  wire logic        outTaken,
  output logic      [23:0] outLeft,
  output logic      [23:0] outRight,
  output logic             outValid,
  // Status
  output logic             muteOut,
  output logic             inStall
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    asrc_pkg::asrc_state_e state;
    logic [8:0]  clrAddr;
    logic [8:0]  inCount;
    logic [11:0] muteCnt;
    logic [15:0] inPeriodCnt;
    logic [15:0] outPeriodCnt;
    logic [15:0] outPeriod;
    logic [15:0] inPeriod;
    logic [15:0] ratio;
    logic [15:0] ratioInv;
    logic [28:0] phase;
    logic [28:0] phaseStep;
    logic        fast;
    logic [3:0]  settleCnt;
    logic [8:0]  rdAddr;
    logic [26:0] romPtr;
    logic [26:0] romStep;
    logic [11:0] tapCnt;
    logic [11:0] tapLimit;
    logic        chan;
    logic signed [47:0] accL;
    logic signed [47:0] accR;
    logic [23:0] outL;
    logic [23:0] outR;
    logic        outV;
    logic        pend;
  } asrc_core_s;

  asrc_core_s st_reg;
  asrc_core_s st_next;

  logic [23:0] ramL [asrc_pkg::RAM_DEPTH];
  logic [23:0] ramR [asrc_pkg::RAM_DEPTH];
  logic        fifoValid;
  logic        fifoReady;
  logic [47:0] fifoData;
  logic        fifoTake;
  logic        ramWe;
  logic [8:0]  ramWa;
  logic [23:0] ramWdL;
  logic [23:0] ramWdR;
  logic [23:0] rdL;
  logic [23:0] rdR;
  logic signed [17:0] coef;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [23:0] scale24(input logic [23:0] s, input logic [15:0] g);
    logic signed [40:0] p;
    p = $signed(s) * $signed({1'b0, g});
    return p[35:12];
  endfunction

  // Coefficient by linear blend of a coarse table
  function automatic logic signed [17:0] coefAt(input logic [20:0] ptr);
    logic signed [17:0] a;
    logic signed [17:0] b;
    logic signed [27:0] d;
    a = 18'sh1FFFF - $signed({3'b000, ptr[19:5]});
    b = 18'sh1FFFF - $signed({3'b000, ptr[19:5] + 15'h0001});
    d = (b - a) * $signed({1'b0, ptr[4:0], 4'h0});
    return 18'(a + 18'(d >>> 9));
  endfunction

  // ----------------------------------------
  // Input buffer
  // ----------------------------------------
  asrc_fifo #(
    .WIDTH (48),
    .DEPTH (asrc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .reset    (reset),
    .inValid  (inFrame),
    .inReady  (fifoReady),
    .inData   ({inLeft, inRight}),
    .outValid (fifoValid),
    .outReady (fifoTake),
    .outData  (fifoData)
  );

  // Drain one word per cycle when idle so RAM port is free
  assign fifoTake = fifoValid && (st_reg.state == asrc_pkg::ASRC_IDLE);
  assign rdL      = ramL[st_reg.rdAddr];
  assign rdR      = ramR[st_reg.rdAddr];
  assign coef     = coefAt(st_reg.romPtr[20:0]);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [15:0] gain;
    logic [23:0] mutedL;
    logic [23:0] mutedR;
    logic [15:0] newRatio;
    logic [15:0] diff;
    logic [36:0] tl;
    gain     = 16'h0000;
    mutedL   = 24'h000000;
    mutedR   = 24'h000000;
    newRatio = 16'h0000;
    diff     = 16'h0000;
    tl       = 37'h0;
    st_next  = st_reg;
    ramWe    = 1'b0;
    ramWa    = 9'h000;
    ramWdL   = 24'h000000;
    ramWdR   = 24'h000000;

    st_next.inPeriodCnt  = st_reg.inPeriodCnt + 16'h0001;
    st_next.outPeriodCnt = st_reg.outPeriodCnt + 16'h0001;

    if (fifoTake) begin
      // Mute then ratio scaling before storing
      gain   = {4'h0, ~st_reg.muteCnt};
      mutedL = scale24(fifoData[47:24], gain);
      mutedR = scale24(fifoData[23:0], gain);
      ramWe  = 1'b1;
      ramWa  = st_reg.inCount + asrc_pkg::WR_OFFSET;
      ramWdL = scale24(mutedL, st_reg.ratioInv);
      ramWdR = scale24(mutedR, st_reg.ratioInv);
      st_next.inCount = st_reg.inCount + 9'h001;
      // Ramp of 4095 frames either way
      if (muteIn && st_reg.muteCnt != asrc_pkg::MUTE_FULL) begin
        st_next.muteCnt = st_reg.muteCnt + 12'h001;
      end else if (!muteIn && st_reg.muteCnt != asrc_pkg::MUTE_NONE) begin
        st_next.muteCnt = st_reg.muteCnt - 12'h001;
      end
    end

    if (inFrame) begin
      st_next.inPeriod    = st_reg.inPeriodCnt;
      st_next.inPeriodCnt = 16'h0000;
    end

    if (outFrame) begin
      // Fast mode takes raw count, slow mode averages
      if (st_reg.fast) begin
        st_next.outPeriod = st_reg.outPeriodCnt;
      end else begin
        st_next.outPeriod = st_reg.outPeriod - (st_reg.outPeriod >> asrc_pkg::SERVO_SHIFT)
                          + (st_reg.outPeriodCnt >> asrc_pkg::SERVO_SHIFT);
      end
      st_next.outPeriodCnt = 16'h0000;
      // Ratio from counters, held at one upsampling
      if (st_reg.inPeriod == 16'h0000 || st_reg.outPeriod <= st_reg.inPeriod) begin
        newRatio = asrc_pkg::RATIO_ONE;
      end else begin
        newRatio = 16'((32'(st_reg.outPeriod) << asrc_pkg::RATIO_FRAC) / st_reg.inPeriod);
        if (newRatio > asrc_pkg::RATIO_MAX) begin
          newRatio = asrc_pkg::RATIO_MAX;
        end
      end
      diff = (newRatio > st_reg.ratio) ? newRatio - st_reg.ratio : st_reg.ratio - newRatio;
      if (newRatio == asrc_pkg::RATIO_ONE || diff > asrc_pkg::RATIO_HYST) begin
        st_next.ratio    = newRatio;
        st_next.ratioInv = 16'(32'h01000000 / {16'h0000, newRatio});
        st_next.phaseStep = 29'(32'(newRatio) << 9);
        if (diff > asrc_pkg::RATIO_HYST) begin
          st_next.fast      = 1'b1;
          st_next.settleCnt = 4'h0;
        end
      end
      // Fast to slow after stable measurements
      if (st_reg.fast) begin
        if (diff <= asrc_pkg::SETTLE_TOL) begin
          st_next.settleCnt = st_reg.settleCnt + 4'h1;
          if (st_reg.settleCnt == asrc_pkg::SETTLE_COUNT) begin
            st_next.fast = 1'b0;
          end
        end else begin
          st_next.settleCnt = 4'h0;
        end
      end
      // Ramp filter tracks input counter
      st_next.phase = {st_reg.inCount, 20'h00000} - st_reg.phaseStep;
    end

    unique case (st_reg.state)
      asrc_pkg::ASRC_CLEAR: begin
        ramWe  = 1'b1;
        ramWa  = st_reg.clrAddr;
        st_next.clrAddr = st_reg.clrAddr + 9'h001;
        if (st_reg.clrAddr == 9'h1FF) begin
          st_next.state = asrc_pkg::ASRC_IDLE;
        end
      end
      asrc_pkg::ASRC_IDLE: begin
        if (st_reg.pend) begin
          st_next.state = asrc_pkg::ASRC_LOAD;
        end
      end
      asrc_pkg::ASRC_LOAD: begin
        // Start pointers from servo
        st_next.rdAddr  = st_reg.phase[28:20];
        st_next.romPtr  = 27'(32'(st_reg.phase[19:0]) * 32'h1000 / st_reg.ratio);
        st_next.romStep = (st_reg.ratio == asrc_pkg::RATIO_ONE) ? 27'(asrc_pkg::ROM_STEP_UNIT)
                        : 27'(32'(asrc_pkg::ROM_STEP_UNIT) * 32'(st_reg.ratioInv) >> 12);
        tl = 37'(st_reg.ratio) * 37'(asrc_pkg::BASE_TAPS);
        st_next.tapLimit = tl[23:12];
        st_next.tapCnt  = 12'h000;
        st_next.chan    = 1'b0;
        st_next.accL    = '0;
        st_next.accR    = '0;
        st_next.pend    = 1'b0;
        st_next.state   = asrc_pkg::ASRC_MAC;
      end
      asrc_pkg::ASRC_MAC: begin
        // Shared multiplier alternates left then right
        if (!st_reg.chan) begin
          // Widen before the product so no bits drop
          st_next.accL = st_reg.accL + 48'($signed(rdL)) * 48'(coef);
          st_next.chan = 1'b1;
        end else begin
          st_next.accR   = st_reg.accR + 48'($signed(rdR)) * 48'(coef);
          st_next.chan   = 1'b0;
          st_next.rdAddr = st_reg.rdAddr - 9'h001;
          st_next.tapCnt = st_reg.tapCnt + 12'h001;
          // Pointer spans 64 phases of 2^20, so rollover is bit 26
          st_next.romPtr = st_reg.romPtr + st_reg.romStep;
          // Rollover or length reached ends
          if (st_next.romPtr[26] || st_next.tapCnt == st_reg.tapLimit) begin
            st_next.state = asrc_pkg::ASRC_DONE;
          end
        end
      end
      asrc_pkg::ASRC_DONE: begin
        st_next.outL  = st_reg.accL[40:17];
        st_next.outR  = st_reg.accR[40:17];
        st_next.outV  = 1'b1;
        st_next.state = asrc_pkg::ASRC_IDLE;
      end
      default: st_next.state = asrc_pkg::ASRC_CLEAR;
    endcase

    if (outTaken) begin
      st_next.outV = 1'b0;
    end
    if (outFrame) begin
      st_next.pend = 1'b1;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg           <= '0;
      st_reg.state     <= asrc_pkg::ASRC_CLEAR;
      st_reg.muteCnt   <= asrc_pkg::MUTE_FULL;
      st_reg.ratio     <= asrc_pkg::RATIO_ONE;
      st_reg.ratioInv  <= asrc_pkg::RATIO_ONE;
      st_reg.phaseStep <= 29'h00200000;
      st_reg.fast      <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
    if (ramWe) begin
      ramL[ramWa] <= ramWdL;
      ramR[ramWa] <= ramWdR;
    end
  end

  // Outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      outLeft  <= 24'h000000;
      outRight <= 24'h000000;
      outValid <= 1'b0;
      muteOut  <= 1'b1;
      inStall  <= 1'b0;
    end else begin
      outLeft  <= st_next.outL;
      outRight <= st_next.outR;
      outValid <= st_next.outV;
      muteOut  <= st_next.fast;
      inStall  <= !fifoReady;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_MUTE_FAST: assert property (@(posedge clk) disable iff (reset)
    muteOut == st_reg.fast) else $error("mute flag mismatch");
  AST_RATIO_ONE: assert property (@(posedge clk) disable iff (reset)
    st_reg.ratio >= asrc_pkg::RATIO_ONE) else $error("ratio below one");
  AST_WR_OFFSET: assert property (@(posedge clk) disable iff (reset)
    fifoTake |-> ramWa == 9'(st_reg.inCount + 9'h010)) else $error("write offset wrong");
  AST_RD_DEC: assert property (@(posedge clk) disable iff (reset)
    (st_reg.state == asrc_pkg::ASRC_MAC && st_reg.chan && st_next.state == asrc_pkg::ASRC_MAC)
    |=> st_reg.rdAddr == $past(st_reg.rdAddr) - 9'h001) else $error("read step wrong");
  AST_LOAD_MAC: assert property (@(posedge clk) disable iff (reset)
    st_reg.state == asrc_pkg::ASRC_LOAD |=> st_reg.state == asrc_pkg::ASRC_MAC
    && st_reg.rdAddr == $past(st_reg.phase[28:20])) else $error("load wrong");
  AST_CONV_END: assert property (@(posedge clk) disable iff (reset)
    st_reg.state == asrc_pkg::ASRC_LOAD |-> ##[2:1000] st_reg.state == asrc_pkg::ASRC_DONE)
    else $error("convolution too long");
  AST_MUTE_RANGE: assert property (@(posedge clk) disable iff (reset)
    fifoTake && muteIn && st_reg.muteCnt != 12'hFFF
    |=> st_reg.muteCnt == $past(st_reg.muteCnt) + 12'h001)
    else $error("mute ramp stalled");
  AST_TAP_LEN: assert property (@(posedge clk) disable iff (reset)
    st_reg.state == asrc_pkg::ASRC_MAC |-> st_reg.tapLimit >= 12'h040) else $error("length short");
  AST_CLEAR: assert property (@(posedge clk) disable iff (reset)
    st_reg.state == asrc_pkg::ASRC_CLEAR |-> ramWe && ramWdL == 24'h000000) else $error("clear bad");
  COV_CONV: cover property (@(posedge clk) st_reg.state == asrc_pkg::ASRC_DONE);
  COV_SLOW: cover property (@(posedge clk) $fell(muteOut));
  COV_DECIM: cover property (@(posedge clk) st_reg.ratio > asrc_pkg::RATIO_ONE);
endmodule

// ==== design/asrc_fifo.sv ====
`timescale 1ns/10ps
module asrc_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
  } asrc_fifo_s;

  logic [WIDTH-1:0] mem [DEPTH];
  asrc_fifo_s       st_reg;
  asrc_fifo_s       st_next;
  logic             doWr;
  logic             doRd;

  assign inReady  = (st_reg.wrPtr - st_reg.rdPtr) != (AW+1)'(DEPTH);
  assign outValid = st_reg.wrPtr != st_reg.rdPtr;
  assign outData  = mem[st_reg.rdPtr[AW-1:0]];
  assign doWr     = inValid && inReady;
  assign doRd     = outValid && outReady;

  always_comb begin
    st_next = st_reg;
    if (doWr) begin
      st_next.wrPtr = st_reg.wrPtr + 1'b1;
    end
    if (doRd) begin
      st_next.rdPtr = st_reg.rdPtr + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
    if (doWr) begin
      mem[st_reg.wrPtr[AW-1:0]] <= inData;
    end
  end
endmodule

// ==== design/asrc_pkg.sv ====
package asrc_pkg;
  // ----------------------------------------
  // Sample store
  // ----------------------------------------
  localparam int          RAM_DEPTH     = 512;
  localparam int          ADDR_W        = 9;
  localparam logic [8:0]  WR_OFFSET     = 9'h010;
  localparam int          DATA_W        = 24;
  localparam int          FIFO_DEPTH    = 32;
  // ----------------------------------------
  // Filter and servo
  // ----------------------------------------
  localparam int          BASE_TAPS     = 64;
  localparam int          FRAC_W        = 20;
  localparam logic [20:0] ROM_STEP_UNIT = 21'h100000;
  localparam int          RATIO_W       = 16;
  localparam int          RATIO_FRAC    = 12;
  localparam logic [15:0] RATIO_ONE     = 16'h1000;
  localparam logic [15:0] RATIO_MAX     = 16'h7C00;
  localparam logic [15:0] RATIO_HYST    = 16'h0002;
  localparam int          PERIOD_W      = 16;
  localparam int          SERVO_SHIFT   = 4;
  localparam logic [3:0]  SETTLE_COUNT  = 4'h8;
  localparam logic [15:0] SETTLE_TOL    = 16'h0004;
  localparam real         SERVO_RES_PS  = 4.97;
  // ----------------------------------------
  // Soft mute
  // ----------------------------------------
  localparam int          MUTE_W        = 12;
  localparam logic [11:0] MUTE_FULL     = 12'hFFF;
  localparam logic [11:0] MUTE_NONE     = 12'h000;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam real         CLK_NS        = 40.0;
  localparam int          CONV_CYC_MAX  = 2 * 7 * 64 + 16;

  typedef enum logic [2:0] {
    ASRC_CLEAR = 3'b000,
    ASRC_IDLE  = 3'b001,
    ASRC_LOAD  = 3'b010,
    ASRC_MAC   = 3'b011,
    ASRC_DONE  = 3'b100
  } asrc_state_e;
endpackage

// ==== verif/asrc_port_model.sv ====
`timescale 1ns/10ps
module asrc_port_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Rates and data from bench
  input  wire logic [15:0] inPer,
  input  wire logic [15:0] outPer,
  input  wire logic [23:0] sample,
  // Converter side
  input  wire logic        outValid,
  output logic             inFrame,
  output logic      [23:0] inLeft,
  output logic      [23:0] inRight,
  output logic             outFrame,
  output logic             outTaken
);
  // ----------------------------------------
  // Frame timers, period zero means silent
  // ----------------------------------------
  logic [15:0] inCnt;
  logic [15:0] outCnt;
  logic [3:0]  takeCnt;

  initial begin
    inFrame  = 1'b0;
    inLeft   = 24'h000000;
    inRight  = 24'h000000;
    outFrame = 1'b0;
    outTaken = 1'b0;
    inCnt    = 16'h0000;
    outCnt   = 16'h0000;
    takeCnt  = 4'h0;
  end

  always @(posedge clk) begin
    inFrame  <= 1'b0;
    outFrame <= 1'b0;
    outTaken <= 1'b0;
    if (reset) begin
      inCnt   <= 16'h0000;
      outCnt  <= 16'h0000;
      takeCnt <= 4'h0;
    end else begin
      if (inPer != 16'h0000 && inCnt + 16'h0001 >= inPer) begin
        inCnt   <= 16'h0000;
        inFrame <= 1'b1;
        inLeft  <= sample;
        inRight <= sample;
      end else begin
        inCnt <= inCnt + 16'h0001;
        // Data only valid with the pulse, so scramble it afterwards
        if (inFrame) begin
          inLeft  <= ~inLeft;
          inRight <= ~inRight;
        end
      end
      if (outPer != 16'h0000 && outCnt + 16'h0001 >= outPer) begin
        outCnt   <= 16'h0000;
        outFrame <= 1'b1;
      end else begin
        outCnt <= outCnt + 16'h0001;
      end
      // Slow reader: takes the result a few cycles late
      if (outValid && !outTaken) begin
        takeCnt <= takeCnt + 4'h1;
        if (takeCnt == 4'h3) begin
          outTaken <= 1'b1;
          takeCnt  <= 4'h0;
        end
      end else begin
        takeCnt <= 4'h0;
      end
    end
  end
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic        clk    = 1'b0;
  logic        reset  = 1'b1;
  logic        muteIn = 1'b1;
  logic [23:0] sample = 24'h000000;
  logic [15:0] inPer  = 16'h0000;
  logic [15:0] outPer = 16'h0000;
  logic        inFrame;
  logic [23:0] inLeft;
  logic [23:0] inRight;
  logic        outFrame;
  logic        outTaken;
  logic [23:0] outLeft;
  logic [23:0] outRight;
  logic        outValid;
  logic        muteOut;
  logic        inStall;
  int          num_errors = 0;
  int          cmp_count  = 0;
  int          rng        = 67113;
  int          cyc        = 0;
  int          resCount   = 0;
  int          startQ[$];
  int          lat;
  int          lo;
  int          hi;
  int          taps;
  bit          prevValid  = 1'b0;
  bit          prevTaken  = 1'b0;
  bit          chkLat     = 1'b0;
  bit          zeroChk    = 1'b0;
  bit          randOn     = 1'b0;
  int          IN_P[3]    = '{1000, 500, 143};
  int          OUT_P[3]   = '{500, 1000, 1000};

  always #20 clk = ~clk;

  asrc_core DUT (
    .clk      (clk),
    .reset    (reset),
    .inFrame  (inFrame),
    .inLeft   (inLeft),
    .inRight  (inRight),
    .muteIn   (muteIn),
    .outFrame (outFrame),
    .outTaken (outTaken),
    .outLeft  (outLeft),
    .outRight (outRight),
    .outValid (outValid),
    .muteOut  (muteOut),
    .inStall  (inStall)
  );

  asrc_port_model PORTS (
    .clk      (clk),
    .reset    (reset),
    .inPer    (inPer),
    .outPer   (outPer),
    .sample   (sample),
    .outValid (outValid),
    .inFrame  (inFrame),
    .inLeft   (inLeft),
    .inRight  (inRight),
    .outFrame (outFrame),
    .outTaken (outTaken)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic int xorshift(input int s);
    int x;
    x = s;
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wait_results(input int n, input int limit);
    int target;
    target = resCount + n;
    for (int i = 0; i < limit; i++) begin
      @(posedge clk);
      if (resCount >= target) return;
    end
    num_errors++;
    give_verdict();
  endtask

  task automatic wait_level(input logic want, input int limit, input bit stall);
    for (int i = 0; i < limit; i++) begin
      @(posedge clk);
      #1;
      if ((stall ? inStall : muteOut) === want) return;
    end
    num_errors++;
    give_verdict();
  endtask

  // ----------------------------------------
  // Result monitor and reference model
  // ----------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (randOn) begin
      rng = xorshift(rng);
      sample <= rng[23:0];
    end
    if (reset) begin
      startQ.delete();
    end else if (outFrame) begin
      startQ.push_back(cyc);
    end
    if (outValid === 1'b1 && !prevValid) begin
      resCount++;
      lat = (startQ.size() > 0) ? cyc - startQ.pop_front() : 0;
      check({8'h00, outRight}, {8'h00, outLeft});
      if (zeroChk) check({8'h00, outLeft}, 32'h00000000);
      if (chkLat) check(32'(lat >= lo && lat <= hi), 32'h00000001);
    end
    // Result must stand until the reader has taken it
    if (prevValid && outValid === 1'b0 && !prevTaken && !reset) begin
      check(32'h00000000, 32'h00000001);
    end
    prevValid = (outValid === 1'b1);
    prevTaken = (outTaken === 1'b1);
  end

  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    give_verdict();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    check(32'(muteOut), 32'h00000001);
    check(32'(outValid), 32'h00000000);
    // Flood the input while the store is being cleared
    @(posedge clk);
    inPer <= 16'h0001;
    wait_level(1'b1, 100, 1'b1);
    @(posedge clk);
    inPer <= 16'h0000;
    wait_level(1'b0, 800, 1'b1);
    zeroChk = 1'b1;
    for (int p = 0; p < 3; p++) begin
      @(posedge clk);
      inPer  <= 16'(IN_P[p]);
      outPer <= 16'(OUT_P[p]);
      // Decimating stretches the filter by the rate ratio
      taps = (OUT_P[p] > IN_P[p]) ? 64 * OUT_P[p] / IN_P[p] : 64;
      lo = 2 * taps * 9 / 10;
      hi = 2 * taps * 11 / 10 + 12;
      if (p > 0) wait_level(1'b1, 6 * OUT_P[p], 1'b0);
      wait_results(4, 8 * OUT_P[p]);
      zeroChk = 1'b0;
      randOn = 1'b1;
      wait_results(8, 12 * OUT_P[p]);
      chkLat = 1'b1;
      wait_results(12, 16 * OUT_P[p]);
      chkLat = 1'b0;
      #1;
      check(32'(muteOut), 32'h00000000);
      muteIn <= 1'b0;
    end
    // Second reset in mid-run
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    #1;
    check(32'(muteOut), 32'h00000001);
    check({7'h00, outValid, outLeft}, 32'h00000000);
    give_verdict();
  end
endmodule
